// ### rtl/async_timer_pkg.sv
// package for the asynchronous timer: register map, fields, timing
// assumes a 32-bit plain register port and a single 25 MHz clock
package async_timer_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CNT    = 8'h04;
  localparam logic [7:0] OFF_STAT   = 8'h08;
  localparam logic [7:0] OFF_SCLR   = 8'h0C;
  localparam logic [7:0] OFF_IEN    = 8'h10;
  localparam logic [7:0] OFF_IDIS   = 8'h14;
  localparam logic [7:0] OFF_IMASK  = 8'h18;
  localparam logic [7:0] OFF_WAKE   = 8'h1C;
  localparam logic [7:0] OFF_ALM0   = 8'h20;
  localparam logic [7:0] OFF_ALM1   = 8'h24;
  localparam logic [7:0] OFF_PER0   = 8'h30;
  localparam logic [7:0] OFF_PER1   = 8'h34;
  localparam logic [7:0] OFF_CLKSRC = 8'h40;
  localparam logic [7:0] OFF_TUNE   = 8'h44;
  localparam logic [7:0] OFF_EVSET  = 8'h48;
  localparam logic [7:0] OFF_EVCLR  = 8'h4C;
  localparam logic [7:0] OFF_EVMASK = 8'h50;
  localparam logic [7:0] OFF_CAL    = 8'h54;
  localparam logic [7:0] OFF_PARAM  = 8'hF0;
  localparam logic [7:0] OFF_REV    = 8'hFC;

  // control fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_PRESCALER_CLEAR_BIT = 1;
  localparam int CTRL_CAL  = 2;
  localparam int CTRL_CA0  = 8;
  localparam int CTRL_PSEL = 16;
  localparam int PSEL_W    = 5;
  localparam logic [31:0] CTRL_MASK = 32'h001F0305;

  // status / source bits
  localparam int ST_OVF   = 0;
  localparam int ST_ALM0  = 8;
  localparam int ST_PER0  = 16;
  localparam int ST_BUSY  = 24;
  localparam int ST_READY = 25;
  localparam logic [31:0] SRC_MASK  = 32'h02030301;
  localparam logic [31:0] WAKE_MASK = 32'h00030301;
  localparam logic [31:0] PER_MASK  = 32'h0000001F;

  // tuner fields
  localparam int TUNE_VAL = 0;
  localparam int TUNE_EXP = 8;
  localparam int TUNE_ADD = 16;
  localparam logic [31:0] TUNE_MASK = 32'h00011FFF;
  localparam logic [7:0] TUNE_EXP_OFS = 8'h08;

  localparam logic [31:0] ZERO32 = 32'h00000000;
  localparam logic [31:0] ONES32 = 32'hFFFFFFFF;

  // write synchronisation time into the counter domain
  localparam int SYNC_NS     = 120;
  localparam int CLK_NS      = 40;
  localparam int SYNC_CYC    = (SYNC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SYNC_CNT = 4'(SYNC_CYC);

  // identity values, arbitrary
  localparam logic [31:0] PARAM_VAL = 32'h00000002;
  localparam logic [31:0] REV_VAL   = 32'h00000100;

  // register port bundle
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // five event lines: ovf, per0, per1, alm0, alm1
  typedef struct packed {
    logic       ovf;
    logic [1:0] per;
    logic [1:0] alm;
  } evt_t;

endpackage

// ### rtl/async_timer.sv
// asynchronous timer: prescaler, counter, periodic/alarm/overflow sources
// assumes one 25 MHz clock; prescaler source enable comes from outside
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

module async_timer
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  // register port
  input  wire async_timer_pkg::reg_req_t req,
  output logic [31:0]                   rdata,
  // prescaler source tick and shutdown return
  input  wire logic                     src_tick,
  input  wire logic                     shutdown_wake,
  // outputs to system
  output logic [4:0]                    irq,
  output async_timer_pkg::evt_t         events,
  output logic                          wake_req
);

  logic [31:0] ctrl_r, cnt_r, stat_r, imask_r, wake_r, evmask_r;
  logic [31:0] alm_r [2];
  logic [31:0] per_r [2];
  logic [31:0] clksrc_r, tune_r, cal_r;
  logic [31:0] pre_r;
  logic [31:0] pre_nxt;
  logic [3:0]  busy_cnt_r;
  logic        busy;
  logic        pend_r;
  async_timer_pkg::reg_req_t pend_req_r;
  logic [31:0] pre_prev_r;
  logic [31:0] tune_acc_r;
  logic [31:0] set_src;
  logic        cnt_step;
  logic [1:0]  per_rise;
  logic [1:0]  alm_hit;
  logic        wrap;
  logic        clr_hit;
  logic        en;

  // bit pick from the prescaler
  function automatic logic tap(input logic [31:0] v, input logic [4:0] s);
    tap = v[s];
  endfunction

  // write strobe for one register address, synced or not
  function automatic logic sw(input async_timer_pkg::reg_req_t r,
                              input logic [7:0]              a);
    sw = r.wr && (r.addr == a);
  endfunction

  assign en   = ctrl_r[async_timer_pkg::CTRL_EN];
  assign busy = (busy_cnt_r != 4'h0);

  // writes to synced registers start busy, dropped while busy
  function automatic logic synced(input logic [7:0] a);
    synced = (a == async_timer_pkg::OFF_CTRL) ||
             (a == async_timer_pkg::OFF_CNT) ||
             (a == async_timer_pkg::OFF_SCLR) ||
             (a == async_timer_pkg::OFF_WAKE) ||
             (a == async_timer_pkg::OFF_EVSET) ||
             (a == async_timer_pkg::OFF_EVCLR) ||
             (a == async_timer_pkg::OFF_ALM0) ||
             (a == async_timer_pkg::OFF_ALM1) ||
             (a == async_timer_pkg::OFF_PER0) ||
             (a == async_timer_pkg::OFF_PER1) ||
             (a == async_timer_pkg::OFF_TUNE);
  endfunction

  // sync window counter, same for any source clock
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      busy_cnt_r <= 4'h0;
      pend_r     <= 1'b0;
      pend_req_r <= '0;
    end
    else if (req.wr && synced(req.addr) && !busy)
    begin
      busy_cnt_r <= async_timer_pkg::SYNC_CNT;
      pend_r     <= 1'b1;
      pend_req_r <= req;
    end
    else if (busy)
    begin
      busy_cnt_r <= busy_cnt_r - 4'h1;
      pend_r     <= (busy_cnt_r != 4'h1);
    end
  end

  // commit strobe: the pending write lands as busy ends
  logic                      commit;
  async_timer_pkg::reg_req_t cw;
  assign commit = pend_r && (busy_cnt_r == 4'h1);
  assign cw     = pend_req_r;

  // control, wake, alarm, interval, tuner, calendar registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_r   <= async_timer_pkg::ZERO32;
      wake_r   <= async_timer_pkg::ZERO32;
      alm_r[0] <= async_timer_pkg::ZERO32;
      alm_r[1] <= async_timer_pkg::ZERO32;
      per_r[0] <= async_timer_pkg::ZERO32;
      per_r[1] <= async_timer_pkg::ZERO32;
      tune_r   <= async_timer_pkg::ZERO32;
      clksrc_r <= async_timer_pkg::ZERO32;
      cal_r    <= async_timer_pkg::ZERO32;
    end
    else
    begin
      // shutdown return leaves these untouched
      if (commit && sw(cw, async_timer_pkg::OFF_CTRL))
        ctrl_r <= cw.wdata & async_timer_pkg::CTRL_MASK;
      if (commit && sw(cw, async_timer_pkg::OFF_WAKE))
        wake_r <= cw.wdata & async_timer_pkg::WAKE_MASK;
      if (commit && sw(cw, async_timer_pkg::OFF_ALM0))
        alm_r[0] <= cw.wdata;
      if (commit && sw(cw, async_timer_pkg::OFF_ALM1))
        alm_r[1] <= cw.wdata;
      if (commit && sw(cw, async_timer_pkg::OFF_PER0))
        per_r[0] <= cw.wdata & async_timer_pkg::PER_MASK;
      if (commit && sw(cw, async_timer_pkg::OFF_PER1))
        per_r[1] <= cw.wdata & async_timer_pkg::PER_MASK;
      if (commit && sw(cw, async_timer_pkg::OFF_TUNE))
        tune_r <= cw.wdata & async_timer_pkg::TUNE_MASK;
      if (sw(req, async_timer_pkg::OFF_CLKSRC))
        clksrc_r <= req.wdata;
      if (sw(req, async_timer_pkg::OFF_CAL))
        cal_r <= req.wdata;
    end
  end

  // tuner: accumulate value, drop or add a step on overflow
  logic [31:0] tune_lim;
  logic [7:0]  tune_val;
  logic [5:0]  tune_pow;
  logic        tune_fire;
  assign tune_val  = tune_r[async_timer_pkg::TUNE_VAL +: 8];
  assign tune_pow  = 6'(tune_r[async_timer_pkg::TUNE_EXP +: 5]) +
                     6'(async_timer_pkg::TUNE_EXP_OFS);
  // limit is two to the exponent+8, minus one; saturates at 32 bits
  assign tune_lim  = (tune_pow >= 6'($bits(tune_lim))) ?
                     async_timer_pkg::ONES32 :
                     ~(async_timer_pkg::ONES32 << tune_pow);
  assign tune_fire = (tune_val != 8'h00) && src_tick && en &&
                     (tune_acc_r + 32'(tune_val) > tune_lim);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      tune_acc_r <= async_timer_pkg::ZERO32;
    else if (tune_val == 8'h00)
      tune_acc_r <= async_timer_pkg::ZERO32;
    else if (src_tick && en)
      tune_acc_r <= tune_fire ? async_timer_pkg::ZERO32
                              : tune_acc_r + 32'(tune_val);
  end

  // prescaler step: tuner adds or removes one increment
  always_comb
  begin
    pre_nxt = pre_r;
    if (src_tick && en)
    begin
      if (!tune_fire)
        pre_nxt = pre_r + 32'h1;
      else if (tune_r[async_timer_pkg::TUNE_ADD])
        pre_nxt = pre_r + 32'h2;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      pre_r <= async_timer_pkg::ZERO32;
    else if (commit && sw(cw, async_timer_pkg::OFF_CTRL) &&
             cw.wdata[async_timer_pkg::CTRL_PRESCALER_CLEAR_BIT])
      pre_r <= async_timer_pkg::ZERO32;
    else
      pre_r <= pre_nxt;
  end

  // tap edge detection on prescaler bits
  logic [4:0] psel;
  assign psel = ctrl_r[async_timer_pkg::CTRL_PSEL +: async_timer_pkg::PSEL_W];

  // last prescaler value; a select change alone makes no edge
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      pre_prev_r <= async_timer_pkg::ZERO32;
    else
      pre_prev_r <= pre_r;
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
      per_rise[i] = en && tap(pre_r, per_r[i][4:0]) &&
                    !tap(pre_prev_r, per_r[i][4:0]);
  end

  assign cnt_step = en && tap(pre_r, psel) &&
                    !tap(pre_prev_r, psel);

  // alarm match and counter
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      alm_hit[i] = en && cnt_step && (cnt_r == alm_r[i]);
  end

  assign clr_hit = |(alm_hit & ctrl_r[async_timer_pkg::CTRL_CA0 +: 2]);
  assign wrap    = cnt_step && (cnt_r == async_timer_pkg::ONES32) &&
                   !ctrl_r[async_timer_pkg::CTRL_CAL];

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cnt_r <= async_timer_pkg::ZERO32;
    else if (commit && sw(cw, async_timer_pkg::OFF_CNT))
      cnt_r <= cw.wdata;
    else if (clr_hit)
      cnt_r <= async_timer_pkg::ZERO32;
    else if (cnt_step)
      cnt_r <= cnt_r + 32'h1;
  end

  // status sources; set wins over clear
  always_comb
  begin
    set_src = async_timer_pkg::ZERO32;
    set_src[async_timer_pkg::ST_OVF]       = wrap || clr_hit;
    set_src[async_timer_pkg::ST_ALM0 +: 2] = alm_hit;
    set_src[async_timer_pkg::ST_PER0 +: 2] = per_rise;
    set_src[async_timer_pkg::ST_READY]     = busy_cnt_r == 4'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      stat_r <= async_timer_pkg::ZERO32;
    else if (commit && sw(cw, async_timer_pkg::OFF_SCLR))
      stat_r <= (stat_r & ~(cw.wdata & async_timer_pkg::SRC_MASK)) |
                set_src;
    else
      stat_r <= stat_r | set_src;
  end

  // irq mask: not synced, cleared on shutdown return
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || shutdown_wake)
      imask_r <= async_timer_pkg::ZERO32;
    else if (sw(req, async_timer_pkg::OFF_IEN))
      imask_r <= imask_r | (req.wdata & async_timer_pkg::SRC_MASK);
    else if (sw(req, async_timer_pkg::OFF_IDIS))
      imask_r <= imask_r & ~req.wdata;
  end

  // event mask
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      evmask_r <= async_timer_pkg::ZERO32;
    else if (commit && sw(cw, async_timer_pkg::OFF_EVSET))
      evmask_r <= evmask_r | (cw.wdata & async_timer_pkg::WAKE_MASK);
    else if (commit && sw(cw, async_timer_pkg::OFF_EVCLR))
      evmask_r <= evmask_r & ~cw.wdata;
  end

  // outputs, all registered
  logic [31:0] irq_lvl;
  assign irq_lvl = stat_r & imask_r;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      irq      <= 5'h00;
      events   <= '0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq[0] <= irq_lvl[async_timer_pkg::ST_OVF];
      irq[1] <= |irq_lvl[async_timer_pkg::ST_PER0 +: 2];
      irq[2] <= |irq_lvl[async_timer_pkg::ST_ALM0 +: 2];
      irq[3] <= 1'b0;
      irq[4] <= irq_lvl[async_timer_pkg::ST_READY];
      events.ovf <= set_src[async_timer_pkg::ST_OVF] &&
                    evmask_r[async_timer_pkg::ST_OVF];
      events.per <= set_src[async_timer_pkg::ST_PER0 +: 2] &
                    evmask_r[async_timer_pkg::ST_PER0 +: 2];
      events.alm <= set_src[async_timer_pkg::ST_ALM0 +: 2] &
                    evmask_r[async_timer_pkg::ST_ALM0 +: 2];
      wake_req <= |(stat_r & wake_r);
    end
  end

  // read data, one cycle after read strobe
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata <= async_timer_pkg::ZERO32;
    else if (req.rd)
    begin
      unique case (req.addr)
        async_timer_pkg::OFF_CTRL:   rdata <= ctrl_r;
        async_timer_pkg::OFF_CNT:    rdata <= cnt_r;
        async_timer_pkg::OFF_STAT:   rdata <= stat_r |
                                     (32'(busy) << async_timer_pkg::ST_BUSY);
        async_timer_pkg::OFF_IMASK:  rdata <= imask_r;
        async_timer_pkg::OFF_WAKE:   rdata <= wake_r;
        async_timer_pkg::OFF_ALM0:   rdata <= alm_r[0];
        async_timer_pkg::OFF_ALM1:   rdata <= alm_r[1];
        async_timer_pkg::OFF_PER0:   rdata <= per_r[0];
        async_timer_pkg::OFF_PER1:   rdata <= per_r[1];
        async_timer_pkg::OFF_CLKSRC: rdata <= clksrc_r;
        async_timer_pkg::OFF_TUNE:   rdata <= tune_r;
        async_timer_pkg::OFF_EVMASK: rdata <= evmask_r;
        async_timer_pkg::OFF_CAL:    rdata <= cal_r;
        async_timer_pkg::OFF_PARAM:  rdata <= async_timer_pkg::PARAM_VAL;
        async_timer_pkg::OFF_REV:    rdata <= async_timer_pkg::REV_VAL;
        default:                     rdata <= async_timer_pkg::ZERO32;
      endcase
    end
  end

endmodule

// ### dv/tick_source.sv
// prescaler source model: one tick per period while running
// assumes the bench drives run and period after a clock edge
`timescale 1ns/1ps
module tick_source
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // control from the bench
  input  wire logic       run,
  input  wire logic [3:0] period,
  // source enable toward the timer
  output logic            src_tick
);
  logic [3:0] cnt_r;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !run || (cnt_r + 4'h1 >= period))
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
  end
  // stands still while stopped
  assign src_tick = run && (cnt_r == 4'h0);
endmodule

// ### dv/async_timer_monitor.sv
// checker on the timer ports
// assumes binding onto async_timer from the bench top
`timescale 1ns/1ps
module async_timer_monitor
(
  // clock and reset
  input wire logic                      sys_clk,
  input wire logic                      sys_rst,
  // register port
  input wire async_timer_pkg::reg_req_t req,
  input wire logic [31:0]               rdata,
  // source and shutdown
  input wire logic                      src_tick,
  input wire logic                      shutdown_wake,
  // outputs
  input wire logic [4:0]                irq,
  input wire async_timer_pkg::evt_t     events,
  input wire logic                      wake_req
);
  logic [3:0] quiet_r;
  logic       hit;
  logic       ien_wr;
  logic       ctl_rd;
  assign ien_wr = req.wr && (req.addr == async_timer_pkg::OFF_IEN);
  assign ctl_rd = req.rd && (req.addr == async_timer_pkg::OFF_CTRL);
  assign hit = shutdown_wake || (req.wr &&
    (req.addr == async_timer_pkg::OFF_SCLR ||
     req.addr == async_timer_pkg::OFF_WAKE ||
     req.addr == async_timer_pkg::OFF_IDIS));
  // cycles since anything that may drop a request
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || hit)
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hF)
      quiet_r <= quiet_r + 4'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  per_gap_a: assert property (
    (events.per != 2'b00) |=> (events.per & $past(events.per)) == 2'b00)
    else $error("periodic event held two cycles");
  idle_src_a: assert property (
    (!src_tick) [*6] |-> events.per == 2'b00)
    else $error("periodic event without source ticks");
  wake_hold_a: assert property (
    wake_req && quiet_r > 4'h5 |=> wake_req)
    else $error("wake request dropped without clear");
  irq_hold_a: assert property (
    irq[2] && !hit && quiet_r > 4'h5 |=> irq[2])
    else $error("alarm request dropped without clear");
  shut_mask_a: assert property (
    (shutdown_wake && !ien_wr) ##1 (!ien_wr) [*2] |-> irq == 5'h00)
    else $error("interrupt after shutdown return");
  prescaler_clear_bit_zero_a: assert property (
    ctl_rd |=> rdata[1] == 1'b0)
    else $error("prescaler clear reads one");
  ctrl_field_a: assert property (
    ctl_rd |=> (rdata & ~async_timer_pkg::CTRL_MASK) == 32'h00000000)
    else $error("control reads undefined bits");
  spare_irq_a: assert property (
    irq[3] == 1'b0)
    else $error("unused request line high");
endmodule

// ### dv/tb_top.sv
// bench for the timer: register tasks and directed tests
// assumes the design package, tick source and monitor files
`timescale 1ns/1ps
module tb_top;
  logic                      sys_clk;
  logic                      sys_rst;
  logic                      shutdown_wake;
  logic                      run;
  logic                      src_tick;
  logic                      wake_req;
  logic [31:0]               rdata;
  logic [4:0]                irq;
  async_timer_pkg::reg_req_t req;
  async_timer_pkg::evt_t     events;
  int                        n_errors = 0;
  int                        comparisons = 0;
  int                        n_per1 = 0;
  int                        n_ovf = 0;
  int                        n_alm = 0;
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  async_timer u_async_timer (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .req(req), .rdata(rdata), .src_tick(src_tick),
    .shutdown_wake(shutdown_wake), .irq(irq), .events(events),
    .wake_req(wake_req));
  tick_source u_tick_source (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .run(run), .period(4'h1), .src_tick(src_tick));
  always @(negedge sys_clk)
  begin
    n_per1 += int'(events.per[1] === 1'b1);
    n_ovf += int'(events.ovf === 1'b1);
    n_alm += int'((|events.alm) === 1'b1);
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int g);
    @(posedge sys_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
    repeat (g) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    req <= '{a, 32'h00000000, 1'b0, 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask
  task automatic wait_irq(input int b);
    for (int k = 0; k < 200 && irq[b] !== 1'b1; k++)
      @(negedge sys_clk);
    cmp({31'h00000000, irq[b]}, 32'h00000001);
    @(posedge sys_clk);
  endtask
  task automatic count_per1(input int exp);
    int base;
    repeat (10) @(posedge sys_clk);
    base = n_per1;
    repeat (64) @(posedge sys_clk);
    cmp(n_per1 - base, exp);
  endtask
  task automatic end_of_test;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end
  initial
  begin
    int ovf_base;
    int alm_base;
    req = '0;
    shutdown_wake = 1'b0;
    run = 1'b0;
    sys_rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 'h58; a += 4)
      rd(8'(a), 32'h00000000);
    rd(async_timer_pkg::OFF_PARAM, async_timer_pkg::PARAM_VAL);
    rd(async_timer_pkg::OFF_REV, async_timer_pkg::REV_VAL);
    $display("test reset values done");
    wr(async_timer_pkg::OFF_IEN, async_timer_pkg::SRC_MASK, 0);
    wr(async_timer_pkg::OFF_EVSET, async_timer_pkg::SRC_MASK, 5);
    wr(async_timer_pkg::OFF_ALM0, 32'h00000003, 0);
    wr(async_timer_pkg::OFF_ALM0, 32'h00000009, 5);
    rd(async_timer_pkg::OFF_ALM0, 32'h00000003);
    rd(async_timer_pkg::OFF_IMASK, async_timer_pkg::SRC_MASK);
    $display("test write sync done");
    wr(async_timer_pkg::OFF_CTRL, 32'h00000101, 0);
    run <= 1'b1;
    wait_irq(2);
    wait_irq(0);
    run <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(async_timer_pkg::OFF_STAT, async_timer_pkg::SRC_MASK);
    $display("test alarm done");
    wr(async_timer_pkg::OFF_WAKE, 32'h00000100, 5);
    cmp({31'h00000000, wake_req}, 32'h00000001);
    @(posedge sys_clk);
    shutdown_wake <= 1'b1;
    @(posedge sys_clk);
    shutdown_wake <= 1'b0;
    repeat (3) @(posedge sys_clk);
    cmp({27'h0000000, irq}, 32'h00000000);
    rd(async_timer_pkg::OFF_IMASK, 32'h00000000);
    rd(async_timer_pkg::OFF_CTRL, 32'h00000101);
    rd(async_timer_pkg::OFF_STAT, async_timer_pkg::SRC_MASK);
    wr(async_timer_pkg::OFF_SCLR, async_timer_pkg::SRC_MASK, 5);
    cmp({31'h00000000, wake_req}, 32'h00000000);
    rd(async_timer_pkg::OFF_STAT, 32'h02000000);
    $display("test wake and shutdown done");
    wr(async_timer_pkg::OFF_PER1, 32'h00000002, 5);
    wr(async_timer_pkg::OFF_CTRL, 32'h00000001, 5);
    run <= 1'b1;
    count_per1(8);
    wr(async_timer_pkg::OFF_CTRL, 32'h00000000, 5);
    count_per1(0);
    wr(async_timer_pkg::OFF_TUNE, 32'h00000080, 5);
    wr(async_timer_pkg::OFF_CTRL, 32'h00000001, 5);
    count_per1(4);
    wr(async_timer_pkg::OFF_TUNE, 32'h00010080, 5);
    count_per1(12);
    wr(async_timer_pkg::OFF_TUNE, 32'h00000000, 5);
    wr(async_timer_pkg::OFF_CTRL, 32'h00000000, 5);
    wr(async_timer_pkg::OFF_EVCLR, async_timer_pkg::SRC_MASK, 5);
    rd(async_timer_pkg::OFF_EVMASK, 32'h00000000);
    $display("test periodic done");
    wr(async_timer_pkg::OFF_CNT, 32'hFFFFFFFE, 5);
    wr(async_timer_pkg::OFF_SCLR, async_timer_pkg::SRC_MASK, 5);
    wr(async_timer_pkg::OFF_IEN, 32'h00000001, 0);
    wr(async_timer_pkg::OFF_EVSET, 32'h00000001, 5);
    ovf_base = n_ovf;
    alm_base = n_alm;
    wr(async_timer_pkg::OFF_CTRL, 32'h00000003, 5);
    wait_irq(0);
    rd(async_timer_pkg::OFF_CTRL, 32'h00000001);
    wr(async_timer_pkg::OFF_CTRL, 32'h00000004, 5);
    rd(async_timer_pkg::OFF_CTRL, 32'h00000004);
    cmp(n_ovf - ovf_base, 1);
    cmp(n_alm - alm_base, 0);
    run <= 1'b0;
    $display("test wrap and control done");
    end_of_test();
  end
endmodule
bind async_timer async_timer_monitor u_async_timer_monitor (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
  .src_tick(src_tick), .shutdown_wake(shutdown_wake), .irq(irq),
  .events(events), .wake_req(wake_req));
